//--- pkg/stx_pkg.sv
// shared constants and types of the serial byte transmitter
package stx_pkg;

    // widths
    localparam int BYTE_W = 8;
    localparam int CODE_W = 10;
    localparam int LFSR_W = 9;

    // bit clock runs at ten times the byte rate
    localparam int          BITS_PER_BYTE = 10;
    localparam logic [3:0]  BIT_CNT_LAST  = 4'h9;
    // read strobe is low for the first half of each byte time
    localparam logic [3:0]  STROBE_LOW_CNT = 4'h5;

    // characters
    localparam logic [7:0]  SYNC_BYTE      = 8'hBC;   // K28.5
    localparam logic [7:0]  LOOP_START     = 8'h00;   // D0.0
    localparam logic [9:0]  SYNC_CODE_RDN  = 10'h0FA; // K28.5 at negative disparity
    localparam logic [9:0]  VIOLATION_CODE = 10'h270; // 100111 0000, never a valid code

    // 5b and 3b field values that matter to the encoder
    localparam logic [4:0]  X_K28 = 5'h1C;
    localparam logic [2:0]  Y_7   = 3'h7;

    // self-test generator, x^9 + x^5 + 1, period 511
    localparam logic [8:0]  LFSR_SEED = 9'h1FF;
    localparam int          LFSR_TAP  = 4;

    // running disparity after reset: negative
    localparam logic        RD_RESET_POS = 1'b0;

    // load sequencer
    typedef enum logic [1:0] {
        LD_IDLE    = 2'b01,
        LD_PENDING = 2'b10
    } stx_load_t;

endpackage

//--- pkg/stx_code_if.sv
// carrier between the transmitter core and its 8b/10b encoder
`timescale 1ns/10ps
interface stx_code_if;
    logic [7:0] data;       // byte held in the input register
    logic       special;    // control-character table selected
    logic       violation;  // send the violation symbol
    logic       bypass;     // raw ten-bit path
    logic [9:0] raw;        // raw code, bit 9 is a
    logic       advance;    // one-cycle pulse: code moves to the shifter
    logic [9:0] code;       // encoded word, bit 9 is a

    modport core (output data, special, violation, bypass, raw, advance, input code);
    modport enc  (input data, special, violation, bypass, raw, advance, output code);
endinterface

//--- verilog/stx_encoder.sv
// 8b/10b encoder with running disparity
`timescale 1ns/10ps
module stx_encoder
(
    // clock and reset
    input  wire logic clk,
    input  wire logic reset,
    // word path
    stx_code_if.enc   cif
);

    logic       rdPosQ;
    logic       rdPosD;
    logic [4:0] x;
    logic [2:0] y;
    logic       isK28;
    logic       kValid;
    logic [5:0] six;
    logic [3:0] four;
    logic       rdMidPos;
    logic       alt;
    logic [9:0] codeW;

    function automatic logic [2:0] ones(input logic [5:0] v);
        ones = 3'(v[0]) + 3'(v[1]) + 3'(v[2]) + 3'(v[3]) + 3'(v[4]) + 3'(v[5]);
    endfunction

    // 5b/6b codes at negative disparity, abcdei
    function automatic logic [5:0] enc6(input logic [4:0] v);
        logic [5:0] t [32];
        t = '{6'h27, 6'h1D, 6'h2D, 6'h31, 6'h35, 6'h29, 6'h19, 6'h38,
              6'h39, 6'h25, 6'h15, 6'h34, 6'h0D, 6'h2C, 6'h1C, 6'h17,
              6'h1B, 6'h23, 6'h13, 6'h32, 6'h0B, 6'h2A, 6'h1A, 6'h3A,
              6'h33, 6'h26, 6'h16, 6'h36, 6'h0E, 6'h2E, 6'h1E, 6'h2B};
        enc6 = t[v];
    endfunction

    // 3b/4b codes at negative disparity, fghj, data and K28 sets
    function automatic logic [3:0] enc4(input logic [2:0] v, input logic k);
        logic [3:0] d [8];
        logic [3:0] c [8];
        d = '{4'hB, 4'h9, 4'h5, 4'hC, 4'hD, 4'hA, 4'h6, 4'hE};
        c = '{4'hB, 4'h6, 4'hA, 4'hC, 4'hD, 4'h5, 4'h9, 4'h7};
        enc4 = k ? c[v] : d[v];
    endfunction

    assign x     = cif.data[4:0];
    assign y     = cif.data[7:5];
    assign isK28 = cif.special && (x == stx_pkg::X_K28);
    // only K28.y and K23/27/29/30.7 exist; anything else is sent as a violation
    assign kValid = isK28 || ((y == stx_pkg::Y_7) &&
                    (x == 5'h17 || x == 5'h1B || x == 5'h1D || x == 5'h1E));

    // code selection and disparity bookkeeping
    always_comb
    begin
        six = isK28 ? 6'h0F : enc6(x);
        if (rdPosQ && (ones(six) != 3'h3 || six == 6'h38))
        begin
            six = ~six;
        end
        rdMidPos = (ones(six) == 3'h3) ? rdPosQ : ~rdPosQ;
        alt = cif.special ||
              (!rdMidPos && (x == 5'h11 || x == 5'h12 || x == 5'h14)) ||
              (rdMidPos && (x == 5'h0B || x == 5'h0D || x == 5'h0E));
        if (!isK28 && y == stx_pkg::Y_7)
        begin
            four = alt ? 4'h7 : 4'hE;
        end
        else
        begin
            four = enc4(y, isK28);
        end
        if (rdMidPos && (isK28 || ones({2'h0, four}) != 3'h2 || four == 4'hC))
        begin
            four = ~four;
        end
        codeW  = {six, four};
        rdPosD = rdPosQ;
        if (cif.bypass)
        begin
            codeW = cif.raw;
        end
        else if (cif.violation || (cif.special && !kValid))
        begin
            codeW = stx_pkg::VIOLATION_CODE;
        end
        else if (cif.advance)
        begin
            rdPosD = (ones({2'h0, four}) == 3'h2) ? rdMidPos : ~rdMidPos;
        end
        if (reset)
        begin
            rdPosD = stx_pkg::RD_RESET_POS;
        end
    end

    always_ff @(posedge clk)
    begin
        rdPosQ <= rdPosD;
    end

    assign cif.code = codeW;

endmodule

//--- verilog/stx_transmitter.sv
// serial 8b/10b transmitter: input register, self-test source, shifter, outputs
//
// What this block does
// - capture inputs on byte clock rising edge
// - immediate enable low loads inputs same edge
// - deferred enable low loads at next edge
// - no enable: send K28.5 that byte time
// - self-test: register becomes 511-byte LFSR
// - special select picks control or data table
// - force input sends code-violation symbol
// - bypass passes raw ten bits, a first
// - bit clock ten times byte clock
// - internal counter times shifter transfer
// - three equal streams, off gates two
// - off control acts within bit times
// - byte-rate read strobe from bit counter
`timescale 1ns/10ps
module stx_transmitter
(
    // clock and reset; clk is the bit clock
    input  wire logic       clk,
    input  wire logic       reset,
    // parallel side, sampled on clk
    input  wire logic       byte_clock_in,
    input  wire logic       load_now_enable_n,
    input  wire logic       load_next_enable_n,
    input  wire logic [7:0] parallel_data_in,
    input  wire logic       special_char_select,
    input  wire logic       force_violation,
    input  wire logic [9:0] raw_code_in,
    // modes
    input  wire logic       encoder_bypass,
    input  wire logic       self_test_enable_n,
    input  wire logic       output_off_control,
    // serial outputs, true and complement
    output logic            serial_out_first_p,
    output logic            serial_out_first_n,
    output logic            serial_out_second_p,
    output logic            serial_out_second_n,
    output logic            serial_out_loopback_p,
    output logic            serial_out_loopback_n,
    // fifo read strobe, active low
    output logic            fifo_read_strobe_n
);

    ////////////////////////////////////////////////////////////////////////////
    // state

    logic              byteClkQ;
    logic              byteClkD;
    logic              byteEdge;
    stx_pkg::stx_load_t loadQ;
    stx_pkg::stx_load_t loadD;
    logic [7:0]        dataQ;
    logic [7:0]        dataD;
    logic              specialQ;
    logic              specialD;
    logic              violQ;
    logic              violD;
    logic [9:0]        rawQ;
    logic [9:0]        rawD;
    logic [8:0]        lfsrQ;
    logic [8:0]        lfsrD;
    logic [3:0]        bitCntQ;
    logic [3:0]        bitCntD;
    logic              transfer;
    logic [9:0]        shiftQ;
    logic [9:0]        shiftD;
    logic              firstD;
    logic              secondD;
    logic              loopD;
    logic              strobeND;

    stx_code_if cif ();

    // one step of the self-test generator
    function automatic logic [8:0] lfsr_step(input logic [8:0] s);
        lfsr_step = {s[7:0], s[8] ^ s[stx_pkg::LFSR_TAP]};
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // byte clock edge detect; the byte clock is a plain synchronous input here

    always_comb
    begin
        byteClkD = reset ? 1'b0 : byte_clock_in;
    end

    always_ff @(posedge clk)
    begin
        byteClkQ <= byteClkD;
    end

    assign byteEdge = byte_clock_in && !byteClkQ;

    ////////////////////////////////////////////////////////////////////////////
    // input register, load sequencer and self-test generator

    always_comb
    begin
        loadD    = loadQ;
        dataD    = dataQ;
        specialD = specialQ;
        violD    = violQ;
        rawD     = rawQ;
        lfsrD    = lfsrQ;
        if (self_test_enable_n)
        begin
            // leaving self-test restarts the pattern from its seed
            lfsrD = stx_pkg::LFSR_SEED;
        end
        if (byteEdge)
        begin
            loadD = load_next_enable_n ? stx_pkg::LD_IDLE
                                       : stx_pkg::LD_PENDING;
            if (!self_test_enable_n)
            begin
                // the 9-bit state spans data bits and the special select,
                // so data, control and violation codes all appear
                lfsrD    = lfsr_step(lfsrQ);
                dataD    = (lfsrQ == stx_pkg::LFSR_SEED) ? stx_pkg::LOOP_START
                                                          : lfsrQ[7:0];
                specialD = (lfsrQ != stx_pkg::LFSR_SEED) && lfsrQ[8];
                violD    = 1'b0;
                rawD     = {lfsrQ[7:0], lfsrQ[8], lfsrQ[0]};
            end
            else
            begin
                case (loadQ)
                    stx_pkg::LD_PENDING:
                    begin
                        // deferred load takes whatever stands now
                        dataD    = parallel_data_in;
                        specialD = special_char_select;
                        violD    = force_violation;
                        rawD     = raw_code_in;
                    end
                    stx_pkg::LD_IDLE:
                    begin
                        if (!load_now_enable_n)
                        begin
                            dataD    = parallel_data_in;
                            specialD = special_char_select;
                            violD    = force_violation;
                            rawD     = raw_code_in;
                        end
                        else
                        begin
                            // idle fill keeps the far end framed
                            dataD    = stx_pkg::SYNC_BYTE;
                            specialD = 1'b1;
                            violD    = 1'b0;
                            rawD     = stx_pkg::SYNC_CODE_RDN;
                        end
                    end
                    default:
                    begin
                        dataD    = stx_pkg::SYNC_BYTE;
                        specialD = 1'b1;
                        violD    = 1'b0;
                        rawD     = stx_pkg::SYNC_CODE_RDN;
                    end
                endcase
            end
        end
        if (reset)
        begin
            loadD    = stx_pkg::LD_IDLE;
            dataD    = stx_pkg::SYNC_BYTE;
            specialD = 1'b1;
            violD    = 1'b0;
            rawD     = stx_pkg::SYNC_CODE_RDN;
            lfsrD    = stx_pkg::LFSR_SEED;
        end
    end

    always_ff @(posedge clk)
    begin
        loadQ    <= loadD;
        dataQ    <= dataD;
        specialQ <= specialD;
        violQ    <= violD;
        rawQ     <= rawD;
        lfsrQ    <= lfsrD;
    end

    ////////////////////////////////////////////////////////////////////////////
    // encoder

    assign cif.data      = dataQ;
    assign cif.special   = specialQ;
    assign cif.violation = violQ;
    assign cif.bypass    = encoder_bypass;
    assign cif.raw       = rawQ;
    assign cif.advance   = transfer;

    stx_encoder u_encoder
    (
        .clk   (clk),
        .reset (reset),
        .cif   (cif)
    );

    ////////////////////////////////////////////////////////////////////////////
    // bit counter: free running, so transfers never follow pin timing

    always_comb
    begin
        if (reset || bitCntQ == stx_pkg::BIT_CNT_LAST)
        begin
            bitCntD = 4'h0;
        end
        else
        begin
            bitCntD = bitCntQ + 4'h1;
        end
    end

    always_ff @(posedge clk)
    begin
        bitCntQ <= bitCntD;
    end

    assign transfer = (bitCntQ == stx_pkg::BIT_CNT_LAST);

    ////////////////////////////////////////////////////////////////////////////
    // shifter, bit a leaves first

    always_comb
    begin
        if (reset)
        begin
            shiftD = stx_pkg::SYNC_CODE_RDN;
        end
        else if (transfer)
        begin
            shiftD = cif.code;
        end
        else
        begin
            shiftD = {shiftQ[8:0], 1'b0};
        end
    end

    always_ff @(posedge clk)
    begin
        shiftQ <= shiftD;
    end

    ////////////////////////////////////////////////////////////////////////////
    // output stage and read strobe
    // the off control is applied per bit, so a byte can be cut mid-way

    always_comb
    begin
        loopD    = shiftQ[9];
        firstD   = shiftQ[9] && !output_off_control;
        secondD  = shiftQ[9] && !output_off_control;
        strobeND = !(bitCntQ < stx_pkg::STROBE_LOW_CNT);
        if (reset)
        begin
            loopD    = 1'b0;
            firstD   = 1'b0;
            secondD  = 1'b0;
            strobeND = 1'b1;
        end
    end

    always_ff @(posedge clk)
    begin
        serial_out_first_p    <= firstD;
        serial_out_first_n    <= !firstD;
        serial_out_second_p   <= secondD;
        serial_out_second_n   <= !secondD;
        serial_out_loopback_p <= loopD;
        serial_out_loopback_n <= !loopD;
        fifo_read_strobe_n    <= strobeND;
    end

endmodule

//--- bench/stx_props.sv
// pin-level assertions of the serial transmitter
`timescale 1ns/10ps
module stx_checker
(
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // modes
    input wire logic encoder_bypass,
    input wire logic output_off_control,
    // serial side
    input wire logic serial_out_first_p,
    input wire logic serial_out_first_n,
    input wire logic serial_out_second_p,
    input wire logic serial_out_second_n,
    input wire logic serial_out_loopback_p,
    input wire logic serial_out_loopback_n,
    input wire logic fifo_read_strobe_n
);
    logic [9:0] lineBits_d, lineBits_q;
    logic [4:0] encRun_d, encRun_q;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);
    ////////////////////////////////////////
    // last ten line bits; a word is judged only once bypass has been off long
    // enough that all of it came through the encoder
    always_comb
    begin
        lineBits_d = {lineBits_q[8:0], serial_out_loopback_p};
        encRun_d   = encRun_q + {4'h0, encRun_q != 5'h1F};
        if (reset || encoder_bypass)
            encRun_d = 5'h00;
    end
    // helper registers
    always_ff @(posedge clk)
    begin
        lineBits_q <= lineBits_d;
        encRun_q   <= encRun_d;
    end
    ////////////////////////////////////////
    pair_first_a: assert property (serial_out_first_n != serial_out_first_p)
        else $error("first pair not complementary");
    pair_second_a: assert property (serial_out_second_n != serial_out_second_p)
        else $error("second pair not complementary");
    pair_loop_a: assert property (serial_out_loopback_n != serial_out_loopback_p)
        else $error("loopback pair not complementary");
    off_forces_zero_a: assert property ($past(output_off_control) |->
        !serial_out_first_p && !serial_out_second_p) else $error("gated pairs not off");
    streams_equal_a: assert property (!$past(output_off_control) |->
        serial_out_first_p == serial_out_loopback_p &&
        serial_out_second_p == serial_out_loopback_p) else $error("streams differ");
    strobe_shape_a: assert property ($fell(fifo_read_strobe_n) |->
        !fifo_read_strobe_n [*5] ##1 fifo_read_strobe_n [*5] ##1 !fifo_read_strobe_n)
        else $error("read strobe shape wrong");
    strobe_start_a: assert property ($fell(reset) |=>
        !fifo_read_strobe_n [*5] ##1 fifo_read_strobe_n) else $error("strobe start wrong");
    word_balance_a: assert property ($fell(fifo_read_strobe_n) && encRun_q == 5'h1F |->
        $countones(lineBits_q) inside {4, 5, 6}) else $error("encoded word unbalanced");
    cover property ($past(output_off_control) && serial_out_loopback_p);
    cover property ($fell(fifo_read_strobe_n) && encoder_bypass);
    cover property ($fell(fifo_read_strobe_n) && encRun_q == 5'h1F);
endmodule
bind stx_transmitter stx_checker stx_checker_i
(
    .clk, .reset, .encoder_bypass, .output_off_control, .serial_out_first_p,
    .serial_out_first_n, .serial_out_second_p, .serial_out_second_n,
    .serial_out_loopback_p, .serial_out_loopback_n, .fifo_read_strobe_n
);

//--- bench/stx_host_model.sv
// byte clock source standing in for the host controller
`timescale 1ns/10ps
module stx_host_model
(
    // clock and reset
    input  wire logic clk,
    input  wire logic reset,
    // byte clock to the transmitter
    output logic      byteClock
);
    logic [3:0] phase_d, phase_q;
    // ten bit times a period, rate matched: a faster host overwrites waiting bytes
    always_comb
    begin
        phase_d = (reset || phase_q == 4'h9) ? 4'h0 : phase_q + 4'h1;
    end
    // phase register
    always_ff @(posedge clk)
    begin
        phase_q <= phase_d;
    end
    assign byteClock = (phase_q < 4'h5);
endmodule

//--- bench/stx_transmitter_bench.sv
// self-checking bench of the serial transmitter
`timescale 1ns/10ps
module stx_transmitter_bench;
    logic        clk, reset, byteClk, nowN, nextN, sp, vio, byp, stN, off, prevS, offLast;
    logic        firstP, firstN, secP, secN, loopP, loopN, strobeN;
    logic [7:0]  data;
    logic [9:0]  raw, word;
    logic [9:0]  words[$], got[$], want[$];
    logic [31:0] rnd, offRnd;
    int          mismatches, checksDone, i, j;
    stx_host_model stx_host_model_i (.clk(clk), .reset(reset), .byteClock(byteClk));
    stx_transmitter stx_transmitter_i
    (
        .clk(clk), .reset(reset), .byte_clock_in(byteClk), .load_now_enable_n(nowN),
        .load_next_enable_n(nextN), .parallel_data_in(data), .special_char_select(sp),
        .force_violation(vio), .raw_code_in(raw), .encoder_bypass(byp),
        .self_test_enable_n(stN), .output_off_control(off),
        .serial_out_first_p(firstP), .serial_out_first_n(firstN),
        .serial_out_second_p(secP), .serial_out_second_n(secN),
        .serial_out_loopback_p(loopP), .serial_out_loopback_n(loopN),
        .fifo_read_strobe_n(strobeN)
    );
    ////////////////////////////////////////
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // the same character at the other running disparity
    function automatic logic [9:0] twin(input logic [9:0] w);
        return ~w;
    endfunction
    task automatic chk(input logic [9:0] seen, input logic [9:0] exp);
        checksDone++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("ERROR at %0t got %h expected %h", $time, seen, exp);
        end
    endtask
    // hold one byte for a whole byte period, so exactly one byte clock rise sees it
    task automatic send(input logic [9:0] r, input logic [7:0] d, input logic s, v, n, x);
        raw   <= r;
        data  <= d;
        sp    <= s;
        vio   <= v;
        nowN  <= n;
        nextN <= x;
        repeat (10) @(posedge clk);
    endtask
    // idle long enough for queued words to leave the line
    task automatic rest;
        repeat (4) send(raw, data, 1'b0, 1'b0, 1'b1, 1'b1);
    endtask
    // drop idle commas, compare the rest in order; encoded mode takes either disparity
    task automatic verify(input logic enc);
        rest();
        got.delete();
        foreach (words[k])
            if (words[k] !== 10'h0FA && !(enc && words[k] === 10'h305))
                got.push_back(words[k]);
        chk(10'(got.size()), 10'(want.size()));
        foreach (want[k])
            chk((enc && got[k] === twin(want[k])) ? want[k] : got[k], want[k]);
        words.delete();
        want.delete();
    endtask
    task automatic results;
        $display("checks %0d mismatches %0d", checksDone, mismatches);
        if (mismatches == 0 && checksDone > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    ////////////////////////////////////////
    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // a word ends where the read strobe falls; bit a leads the next one
    // the gated pairs must follow the loopback pair, cut by the off level one clock back
    always @(negedge clk)
    begin
        if (!reset && prevS === 1'b1 && strobeN === 1'b0)
            words.push_back(word);
        if (!reset)
            chk({5'h00, firstP, firstN, secP, secN, loopN},
                {5'h00, loopP & !offLast, !(loopP & !offLast), loopP & !offLast,
                 !(loopP & !offLast), !loopP});
        prevS   = strobeN;
        offLast = off;
        word    = {word[8:0], loopP};
    end
    // light-off control toggled at random, unrelated to byte boundaries
    always @(posedge clk)
    begin
        offRnd = reset ? 32'h08C76FD6 : lfsr(offRnd);
        off   <= offRnd[4] & offRnd[9];
    end
    // watchdog
    initial
    begin
        repeat (12000) @(posedge clk);
        mismatches++;
        results();
    end
    initial
    begin
        rnd = 32'h08C76FD6;
        {reset, nowN, nextN, stN} = 4'hF;
        {sp, vio, byp, data, raw} = 21'h0;
        mismatches = 0;
        checksDone = 0;
        repeat (12) @(posedge clk);
        reset <= 1'b0;
        repeat (100) @(posedge clk);
        for (i = 3; i < 9; i++)
            chk(words[i], twin(words[i - 1]));
        chk((words[8] === 10'h305) ? 10'h0FA : words[8], 10'h0FA);
        $display("test idle done");
        byp <= 1'b1;
        rest();
        words.delete();
        for (i = 0; i < 8; i++)
        begin
            rnd = lfsr(rnd);
            want.push_back((rnd[9:0] == 10'h0FA) ? 10'h0FB : rnd[9:0]);
            send(want[i], rnd[17:10], 1'b0, 1'b0, 1'b0, 1'b1);
        end
        verify(1'b0);
        send(10'h155, 8'h00, 1'b0, 1'b0, 1'b1, 1'b0);
        send(10'h2A5, 8'h00, 1'b0, 1'b0, 1'b1, 1'b1);
        want = '{10'h2A5};
        verify(1'b0);
        $display("test bypass done");
        byp <= 1'b0;
        rest();
        words.delete();
        send(10'h000, rnd[7:0], 1'b0, 1'b1, 1'b0, 1'b1);
        send(10'h000, 8'h1C, 1'b1, 1'b0, 1'b0, 1'b1);
        send(10'h000, 8'h00, 1'b0, 1'b0, 1'b0, 1'b1);
        want = '{10'h270, 10'h0F4, 10'h274};
        verify(1'b1);
        $display("test encoded done");
        stN <= 1'b0;
        words.delete();
        repeat (5400) @(posedge clk);
        stN <= 1'b1;
        i = 0;
        j = -1;
        foreach (words[k])
            if (words[k] === 10'h274 || words[k] === 10'h18B)
            begin
                if (j >= 0)
                    chk(10'(k - j), 10'h1FF);
                i++;
                j = k;
            end
        chk(10'(i), 10'h002);
        $display("test self-test done");
        results();
    end
endmodule
